// ---- src/stp_pkg.sv ----
/*
 Constants for the sync timing registry and front-panel control block.
 Assumes a 40 MHz system clock and an APB register bus with 12-bit addresses.
*/
package stp_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int GATE_MS = 20;
    localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
    localparam int HZ_PER_CNT = 1000 / GATE_MS;
    localparam int THRESH_HZ = 500;
    localparam logic [11:0] FREQ_THR = 12'(THRESH_HZ / HZ_PER_CNT);
    localparam int OSD_TIMEOUT_S = 10;
    localparam int OSD_CYC = CLK_HZ * OSD_TIMEOUT_S;
    localparam int NFACT = 16;
    localparam int NUSER = 12;
    localparam int NENT = NFACT + NUSER;
    localparam int NITEM = 16;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_FREQ = 12'h008;
    localparam logic [11:0] ADDR_ITEM = 12'h00C;
    localparam logic [3:0] ITEM_CONTRAST = 4'h0;
    localparam logic [7:0] VAL_RST = 8'h80;
    localparam logic [15:0] PERMIT_NORMAL = 16'h03FF;
    localparam logic [15:0] PERMIT_ENH = 16'h8E00;
    localparam logic [15:0] PERMIT_SERIAL = 16'hCFFF;
    localparam logic [15:0] PERMIT_FACT1 = 16'hFFFF;
    localparam logic [15:0] PERMIT_FACT2 = 16'hFDFF;
    localparam logic [15:0] CLASS_TIMING = 16'h3878;
    localparam logic [15:0] RECALL_MASK = 16'h8878;
    localparam logic [15:0] CENTER_MASK = 16'h0383;
    typedef enum logic [2:0] {
        STP_MODE_NORMAL = 3'b000,
        STP_MODE_ENH = 3'b001,
        STP_MODE_FACT1 = 3'b010,
        STP_MODE_FACT2 = 3'b011,
        STP_MODE_SERIAL = 3'b100
    } stp_mode_t;
    typedef enum logic [1:0] {
        STP_SC_IDLE = 2'b00,
        STP_SC_RUN = 2'b01,
        STP_SC_REG = 2'b10
    } stp_scan_t;
endpackage

// ---- src/stp_ctrl.sv ----
/*
 Sync timing registry and front-panel adjustment control, APB slave.
 Assumes sync and button inputs synchronous to clk and already debounced.
*/
// Added by the designer: the APB slave port and the address map.
// Behaviour
// RQ1 - Store holds 16 factory and 12 user timings with polarities and frequencies.
// RQ2 - Input change on polarity flip or frequency move of 0.5 kHz or more.
// RQ3 - Match needs equal polarities and both frequency differences below 0.5 kHz.
// RQ4 - Unmatched incoming timing is written into the store as a new entry.
// RQ5 - Normal/enhanced: free user slot, else replace oldest user entry.
// RQ6 - Factory mode: free factory slot, else overwrite oldest user entry.
// RQ7 - Report matched entry as factory index 0-15 or user index 0-11.
// RQ8 - Select or adjust press starts overlay showing current item.
// RQ9 - Overlay erased after ten idle seconds; selected item kept.
// RQ10 - With rotary adjust source, overlay erase resets item to contrast.
// RQ11 - Select steps through items; adjust changes selected item's value.
// RQ12 - Five adjustment modes, each with its own permitted items.
// RQ13 - Recall in normal/enhanced restores recall-eligible items to factory values.
// RQ14 - Increase plus decrease together set centre-click items to factory values.
// RQ15 - Adjusting centre-click items in factory modes updates their factory values.
// RQ16 - Geometry and gain stored per timing; other items stored once, shared.
// RQ17 - Fine geometry, focus and bias items gated by mode.
// RQ18 - Sync frequencies measured by reference-clock gated counting.
`timescale 1ns/10ps
module stp_ctrl #(
    parameter int GATE_CYCLES = stp_pkg::GATE_CYC,
    parameter int OSD_CYCLES = stp_pkg::OSD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic btn_select,
    input wire logic btn_inc,
    input wire logic btn_dec,
    input wire logic btn_recall,
    output logic osd_on,
    output logic [3:0] osd_item,
    output logic [7:0] osd_value
);
    import stp_pkg::*;

    if (GATE_CYCLES < NENT + 2 || OSD_CYCLES < 2) begin : g_chk
        $error("cycle counts too small");
    end

    localparam int GW = $clog2(GATE_CYCLES + 1);
    localparam int OW = $clog2(OSD_CYCLES + 1);

    function automatic logic [11:0] absdiff(input logic [11:0] a, input logic [11:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    // APB
    logic wr_en;
    logic [2:0] mode_r;
    logic src_rotary_r;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_r <= STP_MODE_NORMAL;
            src_rotary_r <= 1'b0;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            mode_r <= pwdata[2:0];
            src_rotary_r <= pwdata[3];
        end
    end

    // Measurement gate
    logic [GW-1:0] gate_r;
    logic meas_done;
    logic [11:0] hcnt_r, vcnt_r;
    logic [GW-1:0] hhi_r, vhi_r;
    logic hs_q, vs_q;
    logic [11:0] hf_r, vf_r;
    logic hp_r, vp_r, meas_ok_r;
    assign meas_done = (gate_r == GW'(GATE_CYCLES - 1));

    always_ff @(posedge clk) begin
        // Tracks pins in reset too: no false edge after release
        hs_q <= hsync;
        vs_q <= vsync;
        if (!rst_n) begin
            gate_r <= '0;
            hcnt_r <= '0;
            vcnt_r <= '0;
            hhi_r <= '0;
            vhi_r <= '0;
        end else begin
            gate_r <= meas_done ? '0 : gate_r + 1'b1;
            if (meas_done) begin
                hcnt_r <= '0;
                vcnt_r <= '0;
                hhi_r <= '0;
                vhi_r <= '0;
            end else begin
                if (hsync && !hs_q && hcnt_r != 12'hFFF) hcnt_r <= hcnt_r + 1'b1; // RQ18
                if (vsync && !vs_q && vcnt_r != 12'hFFF) vcnt_r <= vcnt_r + 1'b1; // RQ18
                hhi_r <= hhi_r + GW'(hsync);
                vhi_r <= vhi_r + GW'(vsync);
            end
        end
    end

    // Latest measurement; polarity high means positive pulses
    logic changed;
    assign changed = !meas_ok_r || (hhi_r < GW'(GATE_CYCLES / 2)) != hp_r
        || (vhi_r < GW'(GATE_CYCLES / 2)) != vp_r
        || absdiff(hcnt_r, hf_r) >= FREQ_THR || absdiff(vcnt_r, vf_r) >= FREQ_THR; // RQ2

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hf_r <= '0;
            vf_r <= '0;
            hp_r <= 1'b0;
            vp_r <= 1'b0;
            meas_ok_r <= 1'b0;
        end else if (meas_done) begin
            hf_r <= hcnt_r;
            vf_r <= vcnt_r;
            hp_r <= hhi_r < GW'(GATE_CYCLES / 2);
            vp_r <= vhi_r < GW'(GATE_CYCLES / 2);
            meas_ok_r <= 1'b1;
        end
    end

    // Timing store and scan
    logic [NENT-1:0] ent_ok_r;
    logic [NENT-1:0] ent_hp_r, ent_vp_r;
    logic [11:0] ent_hf_r [NENT];
    logic [11:0] ent_vf_r [NENT];
    stp_scan_t sc_r;
    logic [4:0] scan_idx_r, match_idx_r, new_idx;
    logic match_ok_r;
    logic [4:0] fact_cnt_r;
    logic [3:0] user_ptr_r;
    logic hit, fact_mode;
    assign fact_mode = mode_r == STP_MODE_FACT1 || mode_r == STP_MODE_FACT2;
    assign hit = ent_ok_r[scan_idx_r] && ent_hp_r[scan_idx_r] == hp_r
        && ent_vp_r[scan_idx_r] == vp_r
        && absdiff(ent_hf_r[scan_idx_r], hf_r) < FREQ_THR
        && absdiff(ent_vf_r[scan_idx_r], vf_r) < FREQ_THR; // RQ3
    assign new_idx = (fact_mode && fact_cnt_r < 5'(NFACT)) ? fact_cnt_r // RQ6
        : 5'(NFACT) + 5'(user_ptr_r); // RQ5

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sc_r <= STP_SC_IDLE;
            scan_idx_r <= '0;
            match_idx_r <= '0;
            match_ok_r <= 1'b0;
        end else begin
            case (sc_r)
                STP_SC_IDLE: if (meas_done && changed) begin
                    sc_r <= STP_SC_RUN;
                    scan_idx_r <= '0;
                    match_ok_r <= 1'b0;
                end
                STP_SC_RUN: if (hit) begin
                    match_idx_r <= scan_idx_r; // RQ7
                    match_ok_r <= 1'b1;
                    sc_r <= STP_SC_IDLE;
                end else if (scan_idx_r == 5'(NENT - 1)) begin
                    sc_r <= STP_SC_REG;
                end else begin
                    scan_idx_r <= scan_idx_r + 1'b1;
                end
                STP_SC_REG: begin
                    match_idx_r <= new_idx; // RQ7
                    match_ok_r <= 1'b1;
                    sc_r <= STP_SC_IDLE;
                end
                default: sc_r <= STP_SC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ent_ok_r <= '0; // RQ1
            fact_cnt_r <= '0;
            user_ptr_r <= '0;
        end else if (sc_r == STP_SC_REG) begin
            ent_ok_r[new_idx] <= 1'b1; // RQ4
            ent_hp_r[new_idx] <= hp_r;
            ent_vp_r[new_idx] <= vp_r;
            ent_hf_r[new_idx] <= hf_r;
            ent_vf_r[new_idx] <= vf_r;
            if (fact_mode && fact_cnt_r < 5'(NFACT)) begin
                fact_cnt_r <= fact_cnt_r + 1'b1;
            end else begin
                user_ptr_r <= (user_ptr_r == 4'(NUSER - 1)) ? '0 : user_ptr_r + 1'b1; // RQ5
            end
        end
    end

    // Front panel
    logic sel_q, inc_q, dec_q, rcl_q;
    logic sel_p, adj_p, cc_p, rcl_p, any_p;
    logic [OW-1:0] osd_tmr_r;
    logic osd_on_r, osd_tout;
    logic [3:0] item_r, item_nxt;
    logic [15:0] permit;
    assign sel_p = btn_select && !sel_q;
    assign cc_p = btn_inc && btn_dec && !(inc_q && dec_q);
    assign adj_p = !cc_p && ((btn_inc && !inc_q) || (btn_dec && !dec_q));
    assign rcl_p = btn_recall && !rcl_q;
    assign any_p = sel_p || adj_p || cc_p || rcl_p;
    assign osd_tout = osd_on_r && osd_tmr_r == OW'(OSD_CYCLES - 1);

    always_comb begin
        case (mode_r)
            STP_MODE_NORMAL: permit = PERMIT_NORMAL; // RQ12
            STP_MODE_ENH: permit = PERMIT_ENH;
            STP_MODE_FACT1: permit = PERMIT_FACT1; // RQ17
            STP_MODE_FACT2: permit = PERMIT_FACT2;
            STP_MODE_SERIAL: permit = PERMIT_SERIAL;
            default: permit = PERMIT_NORMAL;
        endcase
    end

    // Next permitted item after the current one
    always_comb begin
        item_nxt = item_r;
        for (int k = NITEM - 1; k >= 1; k--) begin
            if (permit[4'(item_r + 4'(k))]) item_nxt = 4'(item_r + 4'(k)); // RQ11
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
            inc_q <= 1'b0;
            dec_q <= 1'b0;
            rcl_q <= 1'b0;
            osd_on_r <= 1'b0;
            osd_tmr_r <= '0;
            item_r <= ITEM_CONTRAST;
        end else begin
            sel_q <= btn_select;
            inc_q <= btn_inc;
            dec_q <= btn_dec;
            rcl_q <= btn_recall;
            if (sel_p || adj_p || cc_p) begin
                osd_on_r <= 1'b1; // RQ8
                osd_tmr_r <= '0;
            end else if (osd_tout) begin
                osd_on_r <= 1'b0; // RQ9
                if (src_rotary_r) item_r <= ITEM_CONTRAST; // RQ10
            end else if (osd_on_r) begin
                osd_tmr_r <= any_p ? '0 : osd_tmr_r + 1'b1;
            end
            if (sel_p && osd_on_r) item_r <= item_nxt; // RQ11
        end
    end

    // Adjustment values
    logic [7:0] cval_r [NITEM];
    logic [7:0] fval_r [NITEM];
    logic [7:0] tval_r [NENT*NITEM];
    logic [8:0] tbase;
    logic [7:0] cur_val, new_val;
    logic user_mode, do_adj;
    assign tbase = 9'(match_idx_r) * 9'(NITEM);
    assign cur_val = CLASS_TIMING[item_r] ? tval_r[tbase + 9'(item_r)] : cval_r[item_r]; // RQ16
    assign new_val = btn_inc ? (cur_val == 8'hFF ? cur_val : cur_val + 1'b1)
        : (cur_val == 8'h00 ? cur_val : cur_val - 1'b1);
    assign user_mode = mode_r == STP_MODE_NORMAL || mode_r == STP_MODE_ENH;
    assign do_adj = adj_p && osd_on_r && permit[item_r]; // RQ17

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NITEM; i++) begin
                cval_r[i] <= VAL_RST;
                fval_r[i] <= VAL_RST;
            end
        end else if (cc_p) begin
            for (int i = 0; i < NITEM; i++) begin
                if (CENTER_MASK[i]) cval_r[i] <= fval_r[i]; // RQ14
            end
        end else if (rcl_p && user_mode) begin
            for (int i = 0; i < NITEM; i++) begin
                if (RECALL_MASK[i] && !CLASS_TIMING[i]) cval_r[i] <= fval_r[i]; // RQ13
            end
        end else if (do_adj && !CLASS_TIMING[item_r]) begin
            cval_r[item_r] <= new_val; // RQ11
            if (fact_mode && CENTER_MASK[item_r]) fval_r[item_r] <= new_val; // RQ15
        end
    end

    always_ff @(posedge clk) begin
        if (rcl_p && user_mode && !cc_p && match_ok_r) begin
            for (int i = 0; i < NITEM; i++) begin
                if (RECALL_MASK[i] && CLASS_TIMING[i]) tval_r[tbase + 9'(i)] <= fval_r[i]; // RQ13
            end
        end else if (do_adj && !cc_p && CLASS_TIMING[item_r] && match_ok_r) begin
            tval_r[tbase + 9'(item_r)] <= new_val; // RQ16
        end
    end

    always_ff @(posedge clk) begin
        osd_value <= cur_val;
    end

    assign osd_on = osd_on_r;
    assign osd_item = item_r;

    // Register read
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            ADDR_CTRL: rdata_nxt = {28'h0, src_rotary_r, mode_r};
            ADDR_STATUS: rdata_nxt = {23'h0, match_ok_r, match_idx_r >= 5'(NFACT),
                (match_idx_r >= 5'(NFACT)) ? 4'(match_idx_r - 5'(NFACT)) : match_idx_r[3:0],
                sc_r == STP_SC_IDLE, vp_r, hp_r}; // RQ7
            ADDR_FREQ: rdata_nxt = {4'h0, vf_r, 4'h0, hf_r};
            ADDR_ITEM: rdata_nxt = {15'h0, osd_on_r, cur_val, 4'h0, item_r};
            default: pslverr = psel && penable;
        endcase
    end

    // Read word caught in setup, held through the access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rdata_nxt;
        end
    end

    a_match_index: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
        sc_r == STP_SC_RUN && hit |=> match_ok_r && match_idx_r == $past(scan_idx_r))
        else $error("matched index wrong");
    a_change_scan: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
        sc_r == STP_SC_IDLE && meas_done && meas_ok_r
        && absdiff(hcnt_r, hf_r) >= FREQ_THR |=> sc_r == STP_SC_RUN)
        else $error("frequency change missed");
    a_new_entry: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
        sc_r == STP_SC_REG |=> ent_ok_r[$past(new_idx)] && ent_hf_r[$past(new_idx)] == hf_r)
        else $error("new timing not stored");
    a_user_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        sc_r == STP_SC_REG && user_mode && user_ptr_r == 4'(NUSER - 1) |=> user_ptr_r == 4'h0)
        else $error("user slot replace order wrong");
    a_osd_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        sel_p || adj_p |=> osd_on_r && osd_tmr_r == '0)
        else $error("overlay not started");
    a_osd_erase: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        osd_tout && !sel_p && !adj_p && !cc_p |=> !osd_on_r)
        else $error("overlay not erased");
    a_rotary_reset: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
        osd_tout && src_rotary_r && !sel_p && !adj_p && !cc_p |=> item_r == ITEM_CONTRAST)
        else $error("item not reset to contrast");
    a_center_click: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
        cc_p |=> cval_r[0] == $past(fval_r[0]) && cval_r[9] == $past(fval_r[9]))
        else $error("centre click not applied");
    a_sel_permit: assert property (@(posedge clk) disable iff (!rst_n) // RQ17
        sel_p && osd_on_r && permit != 16'h0 && !wr_en |=> permit[item_r])
        else $error("select reached forbidden item");
endmodule // stp_ctrl

// ---- testbench/stp_sync_src.sv ----
/*
 Far-side model: a video source giving periodic hsync and vsync pulses.
 Assumes the bench sets periods in clk cycles and changes them at edges.
*/
`timescale 1ns/10ps
module stp_sync_src (
    input wire logic clk,
    input wire logic [7:0] h_per,
    input wire logic [7:0] v_per,
    input wire logic h_pos,
    input wire logic v_pos,
    output logic hsync,
    output logic vsync
);
    logic [7:0] hc_r = 8'h00;
    logic [7:0] vc_r = 8'h00;

    // Period counters, free running
    always_ff @(posedge clk) begin
        hc_r <= (hc_r >= h_per - 8'h01) ? 8'h00 : hc_r + 8'h01;
        vc_r <= (vc_r >= v_per - 8'h01) ? 8'h00 : vc_r + 8'h01;
    end

    // One-cycle pulse a period; short high means positive
    assign hsync = (hc_r == 8'h00) ? h_pos : !h_pos;
    assign vsync = (vc_r == 8'h00) ? v_pos : !v_pos;
endmodule // stp_sync_src

// ---- testbench/sync_timing_registry_control_test.sv ----
/*
 Self-checking bench: APB register access, timing registration, front panel.
 Assumes stp_ctrl with short gate and overlay counts, stp_sync_src as source.
*/
`timescale 1ns/10ps
module sync_timing_registry_control_test;
    import stp_pkg::*;
    localparam int GATE = 400;
    localparam int OSD = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hsync;
    logic vsync;
    logic btn_select = 1'b0;
    logic btn_inc = 1'b0;
    logic btn_dec = 1'b0;
    logic btn_recall = 1'b0;
    logic osd_on;
    logic [3:0] osd_item;
    logic [7:0] osd_value;
    logic [7:0] h_per = 8'h03;
    logic [7:0] v_per = 8'h14;
    logic h_pos = 1'b0;
    logic v_pos = 1'b0;
    int cyc = 0;
    int err_total = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic er;

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

    stp_ctrl #(.GATE_CYCLES(GATE), .OSD_CYCLES(OSD)) i_dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hsync(hsync), .vsync(vsync), .btn_select(btn_select),
        .btn_inc(btn_inc), .btn_dec(btn_dec), .btn_recall(btn_recall),
        .osd_on(osd_on), .osd_item(osd_item), .osd_value(osd_value)
    );

    stp_sync_src i_src (
        .clk(clk), .h_per(h_per), .v_per(v_per), .h_pos(h_pos), .v_pos(v_pos),
        .hsync(hsync), .vsync(vsync)
    );

    task end_sim;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) begin
            err_total++;
            end_sim();
        end
    endtask

    // Buttons as {recall, dec, inc, select}
    task press(input logic [3:0] b);
        @(posedge clk);
        {btn_recall, btn_dec, btn_inc, btn_select} <= b;
        repeat (2) @(posedge clk);
        {btn_recall, btn_dec, btn_inc, btn_select} <= 4'h0;
        repeat (3) @(posedge clk);
    endtask

    // Change near a window edge so a mixed window stays near the old count
    task set_timing(input int i, input logic [7:0] vp);
        int n;
        n = 0;
        while ((cyc % GATE) != GATE - 2 && n < 2 * GATE) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2 * GATE) begin
            err_total++;
            end_sim();
        end
        h_per <= 8'(3 + i % 4);
        v_per <= vp;
        h_pos <= i[2];
        v_pos <= i[3];
    endtask

    task wait_status(input logic [8:0] exp);
        int n;
        n = 0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        while (rd[8:0] !== exp && n < 1000) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        chk("status", {23'h0, exp}, {23'h0, rd[8:0]});
        if (n >= 1000) begin
            end_sim();
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b0, ADDR_ITEM, 32'h0);
        chk("item_reset", 32'h00008000, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        // Twelve user slots, then the oldest is replaced
        for (int i = 0; i < 13; i++) begin
            set_timing(i, 8'h14);
            wait_status({1'b1, 1'b1, 4'(i % 12), 1'b1, i[3], i[2]});
            apb(1'b0, ADDR_FREQ, 32'h0);
            chk("h_count", 32'h1, {31'h0, (rd[11:0] >= 12'(GATE / (3 + i % 4) - 1)
                && rd[11:0] <= 12'(GATE / (3 + i % 4) + 1))});
            chk("v_count", 32'h1, {31'h0, (rd[27:16] >= 12'd19 && rd[27:16] <= 12'd21)});
        end
        apb(1'b1, ADDR_CTRL, 32'h2);
        set_timing(0, 8'h28);
        wait_status({1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0});
        apb(1'b1, ADDR_CTRL, 32'h0);
        set_timing(5, 8'h14);
        wait_status({1'b1, 1'b1, 4'h5, 1'b1, 1'b0, 1'b1});
        press(4'h1);
        chk("osd_open", 32'h1, {31'h0, osd_on});
        chk("item_open", 32'h0, {28'h0, osd_item});
        press(4'h1);
        chk("item_step", 32'h1, {28'h0, osd_item});
        press(4'h2);
        chk("val_inc", 32'h81, {24'h0, osd_value});
        press(4'h6);
        chk("val_centre", 32'h80, {24'h0, osd_value});
        repeat (40) @(posedge clk);
        chk("osd_held", 32'h1, {31'h0, osd_on});
        repeat (20) @(posedge clk);
        chk("osd_off", 32'h0, {31'h0, osd_on});
        chk("item_kept", 32'h1, {28'h0, osd_item});
        apb(1'b1, ADDR_CTRL, 32'h8);
        press(4'h1);
        repeat (70) @(posedge clk);
        chk("item_rotary", 32'h0, {28'h0, osd_item});
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (4) press(4'h1);
        chk("item_hsize", 32'h3, {28'h0, osd_item});
        press(4'h8);
        press(4'h2);
        press(4'h2);
        chk("hsize_inc", 32'h82, {24'h0, osd_value});
        press(4'h8);
        chk("hsize_recall", 32'h80, {24'h0, osd_value});
        apb(1'b1, ADDR_CTRL, 32'h1);
        press(4'h1);
        chk("item_enh", 32'h9, {28'h0, osd_item});
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (7) press(4'h1);
        chk("item_fact", 32'h0, {28'h0, osd_item});
        press(4'h2);
        chk("fact_inc", 32'h81, {24'h0, osd_value});
        apb(1'b1, ADDR_CTRL, 32'h0);
        press(4'h4);
        chk("norm_dec", 32'h80, {24'h0, osd_value});
        press(4'h6);
        chk("fact_value", 32'h81, {24'h0, osd_value});
        apb(1'b1, ADDR_CTRL, 32'h4);
        repeat (12) press(4'h1);
        chk("item_bias", 32'hE, {28'h0, osd_item});
        press(4'h2);
        chk("bias_inc", 32'h81, {24'h0, osd_value});
        apb(1'b1, ADDR_CTRL, 32'h0);
        press(4'h2);
        chk("bias_locked", 32'h81, {24'h0, osd_value});
        apb(1'b0, ADDR_ITEM, 32'h0);
        chk("item_reg", 32'h0001810E, rd);
        apb(1'b1, ADDR_CTRL, 32'h3);
        repeat (11) press(4'h1);
        chk("item_fact2", 32'hA, {28'h0, osd_item});
        end_sim();
    end
endmodule // sync_timing_registry_control_test
